// [rtl/imlu_pkg.sv]
// constants and carrier types for the integer multiply and logic unit
// Summary of operation
// - A primary opcode of zero with function 011000 and bits 15..6 all zero decodes as signed_product_op.
// - signed_product_op multiplies both 32-bit operands as signed values, low half to product_bottom_reg, high to product_upper_reg.
// - Neither multiply ever raises an arithmetic or overflow exception, whatever the operands.
// - A primary opcode of zero with function 011001 and bits 15..6 all zero decodes as unsigned_product_op.
// - unsigned_product_op zero-extends both operands, bits 31..0 go to product_bottom_reg and 63..32 to product_upper_reg.
// - A read of either product register waits in hardware until every outstanding multiply has written its result.
// - The multiplier runs in the background while independent instructions keep issuing, without changing any result.
// - The all-zero word is a shift of register zero by zero into register zero, with no effect and no exception.
// - Function 100111 with a zero shift field writes the complement of the OR of both sources to dest_index.
// - bitwise_disjunction_op writes the OR of both sources to dest_index and raises no exception.
package imlu_pkg;

  // instruction field positions
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int SRC_A_MSB = 25;
  localparam int SRC_A_LSB = 21;
  localparam int SRC_B_MSB = 20;
  localparam int SRC_B_LSB = 16;
  localparam int DEST_MSB = 15;
  localparam int DEST_LSB = 11;
  localparam int SHAMT_MSB = 10;
  localparam int SHAMT_LSB = 6;
  localparam int MUL_PAD_MSB = 15;
  localparam int MUL_PAD_LSB = 6;
  localparam int FN_MSB = 5;
  localparam int FN_LSB = 0;

  // encodings
  localparam logic [5:0] OPC_PRIMARY_ZERO = 6'h00;
  localparam logic [5:0] FN_SIGNED_PRODUCT = 6'h18;
  localparam logic [5:0] FN_UNSIGNED_PRODUCT = 6'h19;
  localparam logic [5:0] FN_NEG_DISJ = 6'h27;
  localparam logic [5:0] FN_DISJ = 6'h25;
  localparam logic [31:0] NULL_WORD = 32'h0000_0000;

  // reset values and timing
  localparam logic [31:0] PROD_RST = 32'h0000_0000;
  localparam int MUL_STAGES = 3;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
  } imlu_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic sel;
    logic [31:0] data;
  } imlu_pacc_t;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [31:0] data;
  } imlu_wb_t;

  typedef struct packed {
    logic valid;
    logic sel;
    logic [31:0] data;
  } imlu_prsp_t;

  typedef struct packed {
    logic [MUL_STAGES-1:0] vld;
    logic [MUL_STAGES-1:0][63:0] prod;
  } imlu_mpipe_t;

  typedef struct packed {
    logic [31:0] prod_bot;
    logic [31:0] prod_upr;
    logic [2:0] cnt;
    logic pend;
    logic pend_wr;
    logic pend_sel;
    logic [31:0] pend_data;
    logic ready;
    imlu_wb_t wb;
    imlu_prsp_t rsp;
  } imlu_core_t;

endpackage

// [rtl/imlu_signed_product_op.sv]
// pipelined 32x32 multiplier, signed or unsigned, fixed latency
`timescale 1ns/100ps
module imlu_prodpipe import imlu_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // operation in
  input wire logic i_start,
  input wire logic i_signed,
  input wire logic [31:0] i_a,
  input wire logic [31:0] i_b,
  // result out
  output logic o_done,
  output logic [63:0] o_prod
);

  imlu_mpipe_t st_r;
  imlu_mpipe_t st_nxt;
  logic [32:0] ext_a;
  logic [32:0] ext_b;
  logic signed [65:0] full_w;

  assign ext_a = {i_signed & i_a[31], i_a};
  assign ext_b = {i_signed & i_b[31], i_b};
  // no overflow check
  // a product of two 33-bit extended operands fits in 64 bits, so no exception path exists
  assign full_w = $signed(ext_a) * $signed(ext_b);

  always_comb begin
    st_nxt = st_r;
    st_nxt.vld[0] = i_start;
    st_nxt.prod[0] = full_w[63:0];
    for (int k = 1; k < MUL_STAGES; k++) begin
      st_nxt.vld[k] = st_r.vld[k-1];
      st_nxt.prod[k] = st_r.prod[k-1];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_done = st_r.vld[MUL_STAGES-1];
  assign o_prod = st_r.prod[MUL_STAGES-1];

  a_pipe_latency: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_start |-> ##3 o_done) else $error("multiply result not out after three cycles");

endmodule

// [rtl/imlu_top.sv]
// multiply and logic execution unit with product registers and interlock
`timescale 1ns/100ps
module imlu_top import imlu_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // instruction issue with operand values
  input wire imlu_req_t i_req,
  // product register access
  input wire imlu_pacc_t i_pacc,
  // flow control
  output logic o_ready,
  // register file write-back
  output imlu_wb_t o_wb,
  // product register read answer
  output imlu_prsp_t o_prsp
);

  imlu_core_t st_r;
  imlu_core_t st_nxt;
  logic acc_i;
  logic acc_p;
  logic prim_w;
  logic [5:0] fn_w;
  logic is_smul;
  logic is_umul;
  logic is_nor;
  logic is_or;
  logic is_null;
  logic m_done;
  logic [63:0] m_prod;
  logic x_go;
  logic x_wr;
  logic x_sel;
  logic [31:0] x_data;

  assign acc_i = i_req.valid & st_r.ready;
  assign acc_p = (i_pacc.rd | i_pacc.wr) & st_r.ready;
  assign prim_w = i_req.instr[OPC_MSB:OPC_LSB] == OPC_PRIMARY_ZERO;
  assign fn_w = i_req.instr[FN_MSB:FN_LSB];

  assign is_smul = acc_i & prim_w & (fn_w == FN_SIGNED_PRODUCT) & (i_req.instr[MUL_PAD_MSB:MUL_PAD_LSB] == '0);
  assign is_umul = acc_i & prim_w & (fn_w == FN_UNSIGNED_PRODUCT) & (i_req.instr[MUL_PAD_MSB:MUL_PAD_LSB] == '0);
  assign is_nor = acc_i & prim_w & (fn_w == FN_NEG_DISJ) & (i_req.instr[SHAMT_MSB:SHAMT_LSB] == '0);
  assign is_or = acc_i & prim_w & (fn_w == FN_DISJ) & (i_req.instr[SHAMT_MSB:SHAMT_LSB] == '0);
  assign is_null = acc_i & (i_req.instr == NULL_WORD);

  // multiplier runs beside the issue path
  imlu_prodpipe u_prod (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(is_smul | is_umul),
    .i_signed(is_smul),
    .i_a(i_req.opnd_a),
    .i_b(i_req.opnd_b),
    .o_done(m_done),
    .o_prod(m_prod)
  );

  // product access waits until no multiply is in flight
  // writes wait too, so a late product cannot overwrite an explicit move
  assign x_go = (acc_p | st_r.pend) & (st_r.cnt == 3'h0);
  assign x_wr = acc_p ? i_pacc.wr : st_r.pend_wr;
  assign x_sel = acc_p ? i_pacc.sel : st_r.pend_sel;
  assign x_data = acc_p ? i_pacc.data : st_r.pend_data;

  always_comb begin
    st_nxt = st_r;
    st_nxt.wb.valid = 1'b0;
    st_nxt.rsp.valid = 1'b0;
    if (is_nor) begin
      st_nxt.wb.valid = 1'b1;
      st_nxt.wb.idx = i_req.instr[DEST_MSB:DEST_LSB];
      st_nxt.wb.data = ~(i_req.opnd_a | i_req.opnd_b);
    end
    if (is_or) begin
      st_nxt.wb.valid = 1'b1;
      st_nxt.wb.idx = i_req.instr[DEST_MSB:DEST_LSB];
      st_nxt.wb.data = i_req.opnd_a | i_req.opnd_b;
    end
    st_nxt.cnt = st_r.cnt + {2'h0, is_smul | is_umul} - {2'h0, m_done};
    if (m_done) begin
      st_nxt.prod_upr = m_prod[63:32];
      st_nxt.prod_bot = m_prod[31:0];
    end
    if (acc_p) begin
      st_nxt.pend = 1'b1;
      st_nxt.pend_wr = i_pacc.wr;
      st_nxt.pend_sel = i_pacc.sel;
      st_nxt.pend_data = i_pacc.data;
    end
    // product regs change only here or on a result
    if (x_go) begin
      st_nxt.pend = 1'b0;
      if (x_wr) begin
        if (x_sel) begin
          st_nxt.prod_upr = x_data;
        end else begin
          st_nxt.prod_bot = x_data;
        end
      end else begin
        st_nxt.rsp.valid = 1'b1;
        st_nxt.rsp.sel = x_sel;
        st_nxt.rsp.data = x_sel ? st_r.prod_upr : st_r.prod_bot;
      end
    end
    st_nxt.ready = ~st_nxt.pend;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.ready <= 1'b1;
      st_r.prod_bot <= PROD_RST;
      st_r.prod_upr <= PROD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ready = st_r.ready;
  assign o_wb = st_r.wb;
  assign o_prsp = st_r.rsp;

  // checking helpers
  logic signed [63:0] sprod_w;
  logic [63:0] uprod_w;
  assign sprod_w = $signed(i_req.opnd_a) * $signed(i_req.opnd_b);
  assign uprod_w = {32'h0, i_req.opnd_a} * {32'h0, i_req.opnd_b};

  a_signed_product: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_smul |-> ##4 ({st_r.prod_upr, st_r.prod_bot} == $past(sprod_w, 4)))
    else $error("signed product halves wrong");

  a_unsigned_product: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_umul |-> ##4 ({st_r.prod_upr, st_r.prod_bot} == $past(uprod_w, 4)))
    else $error("unsigned product halves wrong");

  a_read_interlock: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_prsp.valid |-> $past(st_r.cnt) == 3'h0) else $error("product read answered while multiply in flight");

  a_read_bounded: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (acc_p && i_pacc.rd && !i_pacc.wr) |-> ##[1:5] o_prsp.valid) else $error("product read never answered");

  a_issue_free: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_ready |-> st_r.pend) else $error("issue stalled without pending product access");

  a_null_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_null |=> !o_wb.valid && st_r.cnt == $past(st_r.cnt) - {2'h0, $past(m_done)})
    else $error("all-zero word had an effect");

  a_nor_result: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_nor |=> o_wb.valid && o_wb.data == ~($past(i_req.opnd_a) | $past(i_req.opnd_b))
      && o_wb.idx == $past(i_req.instr[DEST_MSB:DEST_LSB])) else $error("negated or result wrong");

  a_or_result: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    is_or |=> o_wb.valid && o_wb.data == ($past(i_req.opnd_a) | $past(i_req.opnd_b)))
    else $error("or result wrong");

  a_smul_decode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (acc_i && prim_w && fn_w == FN_SIGNED_PRODUCT && i_req.instr[MUL_PAD_MSB:MUL_PAD_LSB] != '0) |-> !is_smul)
    else $error("multiply decoded with nonzero pad bits");

  a_prod_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!m_done && !(x_go && x_wr)) |=> $stable(st_r.prod_bot) && $stable(st_r.prod_upr))
    else $error("product register changed without cause");

endmodule

// [testbench/imlu_issue.sv]
// issue pipeline model: offers requests and holds them until taken
`timescale 1ns/100ps
module imlu_issue import imlu_pkg::*; (
  // clock and flow control
  input wire logic i_ref_clk,
  input wire logic i_ready,
  // requests to the unit
  output imlu_req_t o_req,
  output imlu_pacc_t o_pacc
);
  initial begin
    o_req = '0;
    o_pacc = '0;
  end
  // called just after an edge; returns at the edge that took it
  task automatic send(input imlu_req_t r, input imlu_pacc_t p);
    o_req <= r;
    o_pacc <= p;
    @(posedge i_ref_clk);
    while (i_ready !== 1'b1) @(posedge i_ref_clk);
  endtask
  // released strobes drop to zero and the other lines flip so a stale value never looks valid
  task automatic idle(input int n);
    o_req <= {1'b0, ~o_req[95:0]};
    o_pacc <= {2'b00, ~o_pacc[32:0]};
    repeat (n) @(posedge i_ref_clk);
  endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the multiply and logic unit
`timescale 1ns/100ps
module tb import imlu_pkg::*;;
  typedef struct packed {logic kind; logic [4:0] tag; logic [31:0] data;} imlu_exp_t;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  imlu_req_t i_req;
  imlu_pacc_t i_pacc;
  logic o_ready;
  imlu_wb_t o_wb;
  imlu_prsp_t o_prsp;
  imlu_exp_t exp_q[$];
  imlu_exp_t e;
  logic [31:0] bot_m = PROD_RST;
  logic [31:0] upr_m = PROD_RST;
  int stall_cycles = 0;
  logic [31:0] cv [4] = '{32'hFFFF_FFFF, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0000_0003};
  int num_errors = 0;
  int tests_run = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  imlu_top uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(i_req), .i_pacc(i_pacc),
    .o_ready(o_ready), .o_wb(o_wb), .o_prsp(o_prsp));
  imlu_issue pipe (.i_ref_clk(i_ref_clk), .i_ready(o_ready), .o_req(i_req), .o_pacc(i_pacc));
  task automatic check(input string what, input logic [31:0] x, input logic [31:0] got);
    tests_run++;
    if (got !== x) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, x, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic op(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
    pipe.send('{valid:1'b1, instr:w, opnd_a:a, opnd_b:b}, '0);
  endtask
  task automatic mul(input logic sgn, input logic [31:0] a, input logic [31:0] b, input logic [9:0] pad);
    if (pad == 10'h000) {upr_m, bot_m} = {{32{a[31] & sgn}}, a} * {{32{b[31] & sgn}}, b};
    op({OPC_PRIMARY_ZERO, 5'h01, 5'h02, pad, sgn ? FN_SIGNED_PRODUCT : FN_UNSIGNED_PRODUCT}, a, b);
  endtask
  task automatic lop(input logic neg, input logic [4:0] d, input logic [4:0] sh, input logic [31:0] a,
    input logic [31:0] b);
    if (sh == 5'h00) exp_q.push_back('{1'b0, d, neg ? ~(a | b) : (a | b)});
    op({OPC_PRIMARY_ZERO, 5'h03, 5'h04, d, sh, neg ? FN_NEG_DISJ : FN_DISJ}, a, b);
  endtask
  task automatic pa(input logic rd, input logic wr, input logic sel, input logic [31:0] d);
    if (rd && !wr) exp_q.push_back('{1'b1, {4'h0, sel}, sel ? upr_m : bot_m});
    if (wr && sel) upr_m = d;
    if (wr && !sel) bot_m = d;
    pipe.send('0, '{rd:rd, wr:wr, sel:sel, data:d});
  endtask
  // results must arrive in issue order
  always @(posedge i_ref_clk) begin
    if (!i_rst && o_ready === 1'b0) stall_cycles++;
    if (!i_rst && (o_wb.valid === 1'b1 || o_prsp.valid === 1'b1)) begin
      if (exp_q.size() == 0) check("spare result", 32'h0, 32'h1);
      else begin
        e = exp_q.pop_front();
        check("kind", {31'h0, e.kind}, {31'h0, o_prsp.valid});
        check("index", {27'h0, e.tag}, {27'h0, e.kind ? {4'h0, o_prsp.sel} : o_wb.idx});
        check("data", e.data, e.kind ? o_prsp.data : o_wb.data);
      end
    end
  end
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(17470));
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    check("ready after reset", 32'h1, {31'h0, o_ready});
    for (int k = 0; k < 16; k++) lop(k[0], 5'($urandom_range(31, 1)), 5'h00, $urandom, $urandom);
    for (int k = 0; k < 8; k++) begin
      mul(k[0], cv[k / 2], cv[(k + k / 2) % 4], 10'h000);
      pa(1'b1, 1'b0, 1'b0, '0);
      pa(1'b1, 1'b0, 1'b1, '0);
    end
    // each read right behind a multiply stalls issue for the pipe depth
    check("stall cycles", 32'(8 * MUL_STAGES), 32'(stall_cycles));
    // three multiplies, at most two in flight, logic op overlapping
    mul(1'b1, $urandom, $urandom, 10'h000);
    mul(1'b0, $urandom, $urandom, 10'h000);
    lop(1'b1, 5'h1F, 5'h00, $urandom, $urandom);
    mul(1'b1, $urandom, $urandom, 10'h000);
    pa(1'b1, 1'b0, 1'b1, '0);
    pa(1'b1, 1'b0, 1'b0, '0);
    op(NULL_WORD, $urandom, $urandom);
    mul(1'b0, 32'hFFFF_FFFF, 32'h3, 10'h040);
    mul(1'b1, 32'hFFFF_FFFF, 32'h3, 10'h200);
    lop(1'b0, 5'h05, 5'h01, $urandom, $urandom);
    lop(1'b1, 5'h05, 5'h10, $urandom, $urandom);
    pa(1'b1, 1'b0, 1'b0, '0);
    // moves wait for a multiply, then hold
    mul(1'b0, $urandom, $urandom, 10'h000);
    pa(1'b1, 1'b1, 1'b0, 32'h1234_5678);
    pa(1'b0, 1'b1, 1'b1, 32'hA5A5_5A5A);
    for (int k = 0; k < 3; k++) begin
      pipe.idle(k + 1);
      pa(1'b1, 1'b0, k[0], '0);
    end
    // reset in mid-run brings the product registers back
    pipe.idle(4);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    bot_m = PROD_RST;
    upr_m = PROD_RST;
    @(posedge i_ref_clk);
    check("ready after reset", 32'h1, {31'h0, o_ready});
    pa(1'b1, 1'b0, 1'b0, '0);
    pa(1'b1, 1'b0, 1'b1, '0);
    for (int k = 0; k < 24; k++) begin
      case ($urandom_range(3))
        0: mul(1'($urandom), $urandom, $urandom, 10'h000);
        1: lop(1'($urandom), 5'($urandom_range(31, 1)), 5'h00, $urandom, $urandom);
        2: pa(1'b1, 1'b0, 1'($urandom), '0);
        default: pipe.idle(1);
      endcase
    end
    pipe.idle(10);
    check("pending results", 32'h0, 32'(exp_q.size()));
    give_verdict();
  end
endmodule
